// [hw/i2cm_defs.svh]
// i2cm_defs.svh: timing counts, command word layout and fixed codes
// assumes a 100 MHz mclk; included only by the master design file
`ifndef I2CM_DEFS_SVH
`define I2CM_DEFS_SVH

// ----------------------------------------
// clock and bit rates
// ----------------------------------------
`define I2CM_CLK_HZ 100000000
`define I2CM_STD_BPS 100000
`define I2CM_FAST_BPS 400000
// quarter bit, rounded up so the line never runs faster than the mode
`define I2CM_QTR_STD 16'((`I2CM_CLK_HZ + 4 * `I2CM_STD_BPS - 1) / (4 * `I2CM_STD_BPS))
`define I2CM_QTR_FAST 16'((`I2CM_CLK_HZ + 4 * `I2CM_FAST_BPS - 1) / (4 * `I2CM_FAST_BPS))
`define I2CM_DIV_W 16

// ----------------------------------------
// command word
// ----------------------------------------
`define I2CM_CMD_W 16
`define I2CM_F_STOP 15
`define I2CM_F_KIND_HI 14
`define I2CM_F_KIND_LO 13
`define I2CM_F_TEN 12
`define I2CM_F_ACK 11
`define I2CM_F_RW 10
`define I2CM_TEN_HDR 5'h1E
`define I2CM_FIFO_DEPTH 16

// ----------------------------------------
// bit counter marks
// ----------------------------------------
`define I2CM_PRE_BIT 4'hF
`define I2CM_LAST_BIT 4'h7
`define I2CM_ACK_SLOT 4'h8

`endif

// [hw/i2cm_fifo.sv]
// i2cm_fifo: small valid/ready buffer with a registered output stage
// assumes one clock; DEPTH a power of two
`timescale 1ns/1ps

module i2cm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // filling side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // draining side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  logic [AW:0] cnt_next;
  logic notFull_reg;
  logic outValid_reg;
  logic [WIDTH-1:0] outData_reg;
  logic push;
  logic load;

  // output stage refills whenever it is empty or being drained
  assign push = inValid & notFull_reg;
  assign load = (cnt_reg != '0) & (~outValid_reg | outReady);
  assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(load);

  // storage, no reset needed on the array
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wp_reg] <= inData;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      notFull_reg <= 1'b0;
    end else begin
      wp_reg <= wp_reg + AW'(push);
      rp_reg <= rp_reg + AW'(load);
      cnt_reg <= cnt_next;
      notFull_reg <= (cnt_next != (AW+1)'(DEPTH));
    end
  end

  // registered read data
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      outValid_reg <= 1'b0;
      outData_reg <= '0;
    end else if (load) begin
      outValid_reg <= 1'b1;
      outData_reg <= mem[rp_reg];
    end else if (outReady) begin
      outValid_reg <= 1'b0;
    end
  end

  assign inReady = notFull_reg;
  assign outValid = outValid_reg;
  assign outData = outData_reg;
endmodule : i2cm_fifo

// [hw/i2cm_master.sv]
// i2cm_master: multi-master two-wire bus controller, byte at a time
// assumes open-drain pads outside with pull-ups, pin mux set beforehand
`timescale 1ns/1ps
`include "i2cm_defs.svh"

// Contract
// - master at 100 or 400 kbit/s
// - data moves as eight-bit units
// - one clock per bit, MSB first
// - ninth bit is acknowledge from receiver
// - data changes only while clock low
// - receiver samples data while clock high
// - data edge with clock high is start/stop
// - lines only pulled low or released
// - lost arbitration cancels transfer, raises flag
// - wait on stretched clock, insert own waits
// - software chooses acknowledge when receiving
// - byte done shown by pollable flag
// - start, stop, repeated start generated on request
// - detect start and stop from any master
// - seven or ten bit address per transfer
// - clock rate from software divider
// - shared bus, contention resolved without corruption
module i2cm_master
  import i2cm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // bus pins, enables low while pulling low
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe_b,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_b,
  // rate selection
  input wire logic fastMode,
  input wire logic [`I2CM_DIV_W-1:0] clkDiv,
  // command stream
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic [`I2CM_CMD_W-1:0] cmdWord,
  // received bytes
  output logic rxValid,
  output logic [7:0] rxData,
  // status
  output logic ackRecv,
  output logic xferDone,
  input wire logic doneClr,
  output logic arbLost,
  input wire logic lostClr,
  output logic busBusy,
  output logic busOwned,
  output logic startSeen,
  output logic stopSeen
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  logic sclMeta_reg, sclSync_reg, sclPrev_reg;
  logic sdaMeta_reg, sdaSync_reg, sdaPrev_reg;
  logic sclRel_reg, sdaRel_reg, lowLvl_reg;
  logic busy_reg, own_reg;
  logic startSeen_reg, stopSeen_reg;
  logic [`I2CM_DIV_W-1:0] tmr_reg;
  logic [`I2CM_DIV_W-1:0] qtr;
  i2cm_state_t st_reg;
  i2cm_phase_t ph_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] secByte_reg;
  logic second_reg, rdMode_reg, ackSel_reg, stopPend_reg;
  logic rxValid_reg, ackRecv_reg, xferDone_reg, arbLost_reg;
  logic [7:0] rxData_reg;
  logic qValid, qTake;
  logic [`I2CM_CMD_W-1:0] qWord;
  i2cm_kind_t qKind;
  logic startEv, stopEv, tick, hiTick, falTick;
  logic sampleNow, byteEnd, lostEv;

  // address byte: ten-bit header or seven-bit address plus direction
  function automatic logic [7:0] addrByte(input logic [`I2CM_CMD_W-1:0] w,
                                          input logic second);
    logic [7:0] b;
    if (!w[`I2CM_F_TEN]) begin
      b = {w[6:0], w[`I2CM_F_RW]};
    end else if (second) begin
      b = w[7:0];
    end else begin
      b = {`I2CM_TEN_HDR, w[9:8], w[`I2CM_F_RW]};
    end
    return b;
  endfunction : addrByte

  // ----------------------------------------
  // command buffer
  // ----------------------------------------
  // a full buffer drops cmdReady so the source really stalls
  i2cm_fifo #(
    .WIDTH(`I2CM_CMD_W),
    .DEPTH(`I2CM_FIFO_DEPTH)
  ) u_cmdq (
    .mclk(mclk),
    .rst_b(rst_b),
    .inValid(cmdValid),
    .inReady(cmdReady),
    .inData(cmdWord),
    .outValid(qValid),
    .outReady(qTake),
    .outData(qWord)
  );

  assign qKind = i2cm_kind_t'(qWord[`I2CM_F_KIND_HI:`I2CM_F_KIND_LO]);
  // a foreign transfer holds the queue until its stop
  assign qTake = qValid && (st_reg == ST_IDLE) && (own_reg || !busy_reg);

  // ----------------------------------------
  // pin synchronisers and bus conditions
  // ----------------------------------------
  // two flops per pin plus a delayed copy; the first stage feeds no logic
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      sclMeta_reg <= sclIn;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
      sdaMeta_reg <= sdaIn;
      sdaSync_reg <= sdaMeta_reg;
      sdaPrev_reg <= sdaSync_reg;
    end
  end

  // data edge under a steady high clock is a condition, never data
  assign startEv = sclSync_reg & sclPrev_reg & sdaPrev_reg & ~sdaSync_reg;
  assign stopEv = sclSync_reg & sclPrev_reg & ~sdaPrev_reg & sdaSync_reg;

  // busy tracking, ours and other masters alike
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy_reg <= 1'b0;
      startSeen_reg <= 1'b0;
      stopSeen_reg <= 1'b0;
    end else begin
      startSeen_reg <= startEv;
      stopSeen_reg <= stopEv;
      if (startEv) begin
        busy_reg <= 1'b1;
      end else if (stopEv) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // quarter-bit timer
  // ----------------------------------------
  // zero divider falls back to the preset of the chosen mode
  assign qtr = (clkDiv != '0) ? clkDiv :
               (fastMode ? `I2CM_QTR_FAST : `I2CM_QTR_STD);
  assign tick = (tmr_reg == '0);
  assign hiTick = tick && (ph_reg == PH_HIGH);
  assign falTick = tick && (ph_reg == PH_FALL);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tmr_reg <= '0;
    end else if (st_reg == ST_IDLE || tick) begin
      tmr_reg <= qtr - `I2CM_DIV_W'(1);
    end else begin
      tmr_reg <= tmr_reg - `I2CM_DIV_W'(1);
    end
  end

  // ----------------------------------------
  // bit strobes
  // ----------------------------------------
  assign sampleNow = (st_reg == ST_BIT) && hiTick;
  assign byteEnd = (st_reg == ST_BIT) && falTick && (bitCnt_reg == `I2CM_ACK_SLOT);
  // we released the line but read low: someone else owns this bit
  assign lostEv = hiTick && !sdaSync_reg &&
                  ((st_reg == ST_START) ||
                   ((st_reg == ST_BIT) && !rdMode_reg && sdaRel_reg &&
                    (bitCnt_reg < `I2CM_ACK_SLOT)));

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // in a data bit scl falls at the high-phase tick, sda moves a quarter later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_IDLE;
      ph_reg <= PH_SET;
      sclRel_reg <= 1'b1;
      sdaRel_reg <= 1'b1;
      own_reg <= 1'b0;
      bitCnt_reg <= `I2CM_PRE_BIT;
      sh_reg <= '0;
      secByte_reg <= '0;
      second_reg <= 1'b0;
      rdMode_reg <= 1'b0;
      ackSel_reg <= 1'b0;
      stopPend_reg <= 1'b0;
    end else if (lostEv) begin
      // let go of both lines at once and drop the transfer
      st_reg <= ST_IDLE;
      sclRel_reg <= 1'b1;
      sdaRel_reg <= 1'b1;
      own_reg <= 1'b0;
      second_reg <= 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          // owning the bus, scl stays low here as our own wait state
          if (qTake) begin
            stopPend_reg <= qWord[`I2CM_F_STOP];
            ackSel_reg <= qWord[`I2CM_F_ACK];
            bitCnt_reg <= `I2CM_PRE_BIT;
            ph_reg <= PH_FALL;
            unique case (qKind)
              CMD_ADDR: begin
                st_reg <= ST_START;
                ph_reg <= PH_SET;
                own_reg <= 1'b1;
                sdaRel_reg <= 1'b1;
                rdMode_reg <= 1'b0;
                sh_reg <= addrByte(qWord, 1'b0);
                secByte_reg <= addrByte(qWord, 1'b1);
                second_reg <= qWord[`I2CM_F_TEN];
              end
              CMD_WRITE: begin
                if (own_reg) begin
                  st_reg <= ST_BIT;
                  rdMode_reg <= 1'b0;
                  sh_reg <= qWord[7:0];
                end
              end
              CMD_READ: begin
                if (own_reg) begin
                  st_reg <= ST_BIT;
                  rdMode_reg <= 1'b1;
                end
              end
              CMD_STOP: begin
                if (own_reg) begin
                  st_reg <= ST_STOP;
                  ph_reg <= PH_SET;
                  sdaRel_reg <= 1'b0;
                end
              end
            endcase
          end
        end
        ST_START, ST_STOP: begin
          if (tick) begin
            unique case (ph_reg)
              PH_SET: begin
                sclRel_reg <= 1'b1;
                ph_reg <= PH_RISE;
              end
              PH_RISE: begin
                // a slave or master holding scl low delays us here
                if (sclSync_reg) begin
                  ph_reg <= PH_HIGH;
                end
              end
              PH_HIGH: begin
                // start pulls sda low, stop lets it rise, scl high
                sdaRel_reg <= (st_reg == ST_STOP);
                ph_reg <= PH_FALL;
              end
              PH_FALL: begin
                if (st_reg == ST_STOP) begin
                  st_reg <= ST_IDLE;
                  own_reg <= 1'b0;
                end else begin
                  sclRel_reg <= 1'b0;
                  st_reg <= ST_BIT;
                end
              end
            endcase
          end
        end
        ST_BIT: begin
          if (tick) begin
            unique case (ph_reg)
              PH_SET: begin
                sclRel_reg <= 1'b1;
                ph_reg <= PH_RISE;
              end
              PH_RISE: begin
                if (sclSync_reg) begin
                  ph_reg <= PH_HIGH;
                end
              end
              PH_HIGH: begin
                // sample at the end of the high phase, then scl low
                if (rdMode_reg && bitCnt_reg < `I2CM_ACK_SLOT) begin
                  sh_reg <= {sh_reg[6:0], sdaSync_reg};
                end
                sclRel_reg <= 1'b0;
                ph_reg <= PH_FALL;
              end
              PH_FALL: begin
                if (bitCnt_reg == `I2CM_ACK_SLOT) begin
                  // byte finished; sda still changes only with scl low
                  bitCnt_reg <= `I2CM_PRE_BIT;
                  if (second_reg) begin
                    second_reg <= 1'b0;
                    sh_reg <= secByte_reg;
                    sdaRel_reg <= 1'b1;
                  end else if (stopPend_reg) begin
                    st_reg <= ST_STOP;
                    ph_reg <= PH_SET;
                    sdaRel_reg <= 1'b0;
                  end else begin
                    st_reg <= ST_IDLE;
                    sdaRel_reg <= 1'b1;
                  end
                end else begin
                  bitCnt_reg <= bitCnt_reg + 4'h1;
                  ph_reg <= PH_SET;
                  if (bitCnt_reg == `I2CM_LAST_BIT) begin
                    // receiver drives the ninth bit
                    sdaRel_reg <= rdMode_reg ? !ackSel_reg : 1'b1;
                  end else if (rdMode_reg) begin
                    sdaRel_reg <= 1'b1;
                  end else if (bitCnt_reg == `I2CM_PRE_BIT) begin
                    sdaRel_reg <= sh_reg[7];
                  end else begin
                    sdaRel_reg <= sh_reg[6];
                    sh_reg <= {sh_reg[6:0], 1'b0};
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // received data, acknowledge result, flags
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxValid_reg <= 1'b0;
      rxData_reg <= '0;
      ackRecv_reg <= 1'b0;
    end else begin
      rxValid_reg <= byteEnd && rdMode_reg;
      if (byteEnd && rdMode_reg) begin
        rxData_reg <= sh_reg;
      end
      if (sampleNow && !rdMode_reg && bitCnt_reg == `I2CM_ACK_SLOT) begin
        ackRecv_reg <= !sdaSync_reg;
      end
    end
  end

  // sticky flags; a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      xferDone_reg <= 1'b0;
      arbLost_reg <= 1'b0;
    end else begin
      xferDone_reg <= byteEnd || (xferDone_reg && !doneClr);
      arbLost_reg <= lostEv || (arbLost_reg && !lostClr);
    end
  end

  // pad data level: open drain only ever drives low
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      lowLvl_reg <= 1'b0;
    end else begin
      lowLvl_reg <= 1'b0;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sclOut = lowLvl_reg;
  assign sdaOut = lowLvl_reg;
  assign sclOe_b = sclRel_reg;
  assign sdaOe_b = sdaRel_reg;
  assign rxValid = rxValid_reg;
  assign rxData = rxData_reg;
  assign ackRecv = ackRecv_reg;
  assign xferDone = xferDone_reg;
  assign arbLost = arbLost_reg;
  assign busBusy = busy_reg;
  assign busOwned = own_reg;
  assign startSeen = startSeen_reg;
  assign stopSeen = stopSeen_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_sda_steady_high: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_reg == ST_BIT && $past(st_reg) == ST_BIT && $past(sclRel_reg) && sclRel_reg)
      |-> $stable(sdaRel_reg))
    else $error("sda moved while scl was released in a data bit");

  chk_open_drain: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !sclOut && !sdaOut)
    else $error("pad level is not low");

  chk_lost_release: assert property (
    @(posedge mclk) disable iff (!rst_b)
    lostEv |=> (sclOe_b && sdaOe_b && st_reg == ST_IDLE && arbLost && !busOwned))
    else $error("arbitration loss did not cancel the transfer");

  chk_busy_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_reg == ST_IDLE && !own_reg && busy_reg) |=> (st_reg != ST_START))
    else $error("start launched on a busy bus");

  chk_done_flag: assert property (
    @(posedge mclk) disable iff (!rst_b)
    byteEnd |=> xferDone ##1 (xferDone || $past(doneClr)))
    else $error("byte completion not flagged");

  chk_msb_first: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_reg == ST_BIT && ph_reg == PH_SET && !rdMode_reg && bitCnt_reg < `I2CM_ACK_SLOT)
      |-> (sdaRel_reg == sh_reg[7]))
    else $error("data bit is not the top of the shift register");

  chk_stretch_wait: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_reg == ST_BIT && ph_reg == PH_RISE && !sclSync_reg && !lostEv) |=> (ph_reg == PH_RISE))
    else $error("high phase entered while scl held low");

  chk_ack_drive: assert property (
    @(posedge mclk) disable iff (!rst_b)
    (st_reg == ST_BIT && rdMode_reg && bitCnt_reg == `I2CM_ACK_SLOT)
      |-> (sdaRel_reg == !ackSel_reg))
    else $error("acknowledge slot not as software chose");

  chk_start_busy: assert property (
    @(posedge mclk) disable iff (!rst_b)
    startEv |=> (busBusy && startSeen) ##1 !startSeen)
    else $error("start condition not reported");
endmodule : i2cm_master

// [hw/i2cm_pkg.sv]
// i2cm_pkg: types shared by the bus master files
// assumes i2cm_defs.svh is on the include path
package i2cm_pkg;
  // sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BIT, ST_STOP} i2cm_state_t;
  // quarter phases of one bus clock period
  typedef enum logic [1:0] {PH_SET, PH_RISE, PH_HIGH, PH_FALL} i2cm_phase_t;
  // command kinds, coded because they arrive on a port
  typedef enum logic [1:0] {
    CMD_ADDR = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } i2cm_kind_t;
endpackage : i2cm_pkg

// [tb/i2cm_master_bench.sv]
// i2cm_master_bench: scenario bench for the two-wire bus master
// assumes the slave model as far side, pull-ups on both lines
`timescale 1ns/1ps

`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_errors++; \
  $display("MISMATCH %0t got %0h want %0h", $time, (a), (e)); end end

module i2cm_master_bench
  import i2cm_pkg::*;
;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic fastMode = 1'b0;
  logic [15:0] clkDiv = 16'h0002;
  logic [15:0] cmdWord = 16'h0000;
  logic cmdValid = 1'b0, doneClr = 1'b0, lostClr = 1'b0, stretch = 1'b0, tbSdaLow = 1'b0;
  logic [7:0] rdByte = 8'h3C;
  logic sclOut, sclOe_b, sdaOut, sdaOe_b, cmdReady, rxValid, ackRecv, xferDone;
  logic arbLost, busBusy, busOwned, startSeen, stopSeen, sLowScl, sLowSda;
  logic [7:0] rxData, firstByte, lastByte;
  wire scl;
  wire sda;
  int n_errors = 0;
  int comparisons = 0;
  int nRx, nDone, nSs, nPs, wS, wP;
  time tFall, minLow;

  // wired-and lines; pins already switched to the bus function
  assign scl = sclOe_b & ~sLowScl;
  assign sda = sdaOe_b & ~sLowSda & ~tbSdaLow;

  i2cm_master i2cm_master_i (
    .mclk(mclk), .rst_b(rst_b), .sclIn(scl), .sclOut(sclOut), .sclOe_b(sclOe_b),
    .sdaIn(sda), .sdaOut(sdaOut), .sdaOe_b(sdaOe_b), .fastMode(fastMode),
    .clkDiv(clkDiv), .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWord(cmdWord),
    .rxValid(rxValid), .rxData(rxData), .ackRecv(ackRecv), .xferDone(xferDone),
    .doneClr(doneClr), .arbLost(arbLost), .lostClr(lostClr), .busBusy(busBusy),
    .busOwned(busOwned), .startSeen(startSeen), .stopSeen(stopSeen)
  );
  i2cm_slave_model i2cm_slave_model_i (
    .scl(scl), .sda(sda), .sclLow(sLowScl), .sdaLow(sLowSda), .stretch(stretch),
    .rdByte(rdByte), .firstByte(firstByte), .lastByte(lastByte)
  );

  // 100 MHz clock
  always #5 mclk = ~mclk;

  // event counts and the shortest clock-low time on the wire
  always @(posedge rxValid) nRx++;
  always @(posedge xferDone) nDone++;
  always @(posedge startSeen) nSs++;
  always @(posedge stopSeen) nPs++;
  always @(negedge scl) tFall = $time;
  always @(posedge scl) if ($time - tFall < minLow) minLow = $time - tFall;
  always @(sda) if (scl === 1'b1 && rst_b === 1'b1) begin
    if (sda === 1'b1) wP++;
    else wS++;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task zero;
    {nRx, nDone, nSs, nPs, wS, wP} = '0;
    minLow = 1000000;
  endtask : zero

  // f holds stop, ten-bit, ack and rw in that order
  function automatic logic [15:0] cw(i2cm_kind_t k, logic [3:0] f, logic [9:0] v);
    return {f[3], k, f[2:0], v};
  endfunction : cw

  // hold the word until the edge that takes it
  task send(input i2cm_kind_t k, input logic [3:0] f, input logic [9:0] v);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdWord <= cw(k, f, v);
    do @(posedge mclk); while (cmdReady !== 1'b1);
    cmdValid <= 1'b0;
  endtask : send

  task waitBus(input logic v, input int lim);
    for (int k = 0; k < lim && busBusy !== v; k++) @(posedge mclk);
    `CHK(busBusy, v)
  endtask : waitBus

  task settle;
    waitBus(1'b1, 3000);
    waitBus(1'b0, 40000);
  endtask : settle

  task clrFlags;
    @(posedge mclk);
    {doneClr, lostClr} <= 2'b11;
    @(posedge mclk);
    {doneClr, lostClr} <= 2'b00;
    @(posedge mclk);
  endtask : clrFlags

  // addressed write of one byte, then stop
  task wr(input logic [7:0] d);
    zero();
    send(CMD_ADDR, 4'h0, 10'h02A);
    send(CMD_WRITE, 4'h8, {2'b00, d});
    settle();
    `CHK(firstByte, 8'h54)
    `CHK(lastByte, d)
    `CHK(ackRecv, 1'b1)
    `CHK({wS, wP, nSs, nPs}, {32'd1, 32'd1, 32'd1, 32'd1})
    `CHK({sclOut, sdaOut}, 2'b00)
  endtask : wr

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // divider, then both presets; clock low lasts two quarters
  task t_rates;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      fastMode <= i == 1;
      clkDiv <= (i == 0) ? 16'h0002 : 16'h0000;
      wr(8'h5A ^ 8'(i));
      `CHK(minLow, time'(20 * ((i == 0) ? 2 : (i == 1) ? 63 : 250)))
      `CHK(xferDone, 1'b1)
      clrFlags();
      `CHK(xferDone, 1'b0)
    end
    @(posedge mclk);
    clkDiv <= 16'h0002;
  endtask : t_rates

  // acknowledged read, then refused read with stop
  task t_read;
    zero();
    send(CMD_ADDR, 4'h1, 10'h02A);
    send(CMD_READ, 4'h2, 10'h000);
    send(CMD_READ, 4'h8, 10'h000);
    settle();
    `CHK(firstByte, 8'h55)
    `CHK({nRx, wP}, {32'd2, 32'd1})
    `CHK(rxData, rdByte)
  endtask : t_read

  // unknown address under clock stretching, explicit stop word
  task t_nack;
    zero();
    @(posedge mclk);
    stretch <= 1'b1;
    send(CMD_ADDR, 4'h0, 10'h011);
    send(CMD_STOP, 4'h0, 10'h000);
    settle();
    stretch <= 1'b0;
    `CHK({ackRecv, wP}, {1'b0, 32'd1})
    `CHK(minLow >= 300, 1'b1)
  endtask : t_nack

  // ten-bit address with the done flag cleared all along
  task t_ten;
    zero();
    @(posedge mclk);
    doneClr <= 1'b1;
    send(CMD_ADDR, 4'h4, 10'h2D5);
    send(CMD_WRITE, 4'h8, 10'h096);
    settle();
    doneClr <= 1'b0;
    `CHK(nDone, 3)
    `CHK({firstByte, lastByte}, 16'hF496)
  endtask : t_ten

  // another master holds the bus; ours waits for its stop
  task t_busy;
    logic drove;
    drove = 1'b0;
    zero();
    @(posedge mclk);
    tbSdaLow <= 1'b1;
    waitBus(1'b1, 100);
    send(CMD_ADDR, 4'h8, 10'h02A);
    repeat (300) begin
      @(posedge mclk);
      drove = drove | ~sclOe_b | ~sdaOe_b;
    end
    `CHK(drove, 1'b0)
    tbSdaLow <= 1'b0;
    waitBus(1'b0, 100);
    settle();
    `CHK({nSs, nPs, ackRecv}, {32'd2, 32'd2, 1'b1})
  endtask : t_busy

  // another master keeps data low on our first address bit
  task t_arb;
    zero();
    send(CMD_ADDR, 4'h8, 10'h07F);
    waitBus(1'b1, 3000);
    @(negedge scl);
    @(posedge mclk);
    tbSdaLow <= 1'b1;
    repeat (20) @(posedge mclk);
    `CHK({arbLost, busOwned, sclOe_b, sdaOe_b}, 4'b1011)
    tbSdaLow <= 1'b0;
    waitBus(1'b0, 100);
    clrFlags();
    `CHK(arbLost, 1'b0)
  endtask : t_arb

  // ----------------------------------------
  // run and verdict
  // ----------------------------------------
  task tally_and_finish;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  // six cycles of reset, then each scenario in turn
  initial begin
    repeat (6) @(posedge mclk);
    `CHK({sclOe_b, sdaOe_b, cmdReady, busBusy}, 4'b1100)
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(cmdReady, 1'b1)
    t_rates();
    t_read();
    t_nack();
    t_ten();
    t_busy();
    t_arb();
    tally_and_finish();
  end

  // cuts a hung handshake short
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
endmodule : i2cm_master_bench

// [tb/i2cm_slave_model.sv]
// i2cm_slave_model: behavioural target device on the two-wire bus
// assumes the bench resolves wired-and lines with pull-ups
`timescale 1ns/1ps

module i2cm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2A
) (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // pull-downs, high pulls the line low
  output logic sclLow = 1'b0,
  output logic sdaLow = 1'b0,
  // control and view
  input wire logic stretch,
  input wire logic [7:0] rdByte,
  output logic [7:0] firstByte,
  output logic [7:0] lastByte
);
  // ----------------------------------------
  // one frame, start to stop
  // ----------------------------------------
  // ten-bit headers are always taken; only the plain address is compared
  task frame;
    int i;
    int n;
    logic [7:0] b;
    logic hit;
    logic rd;
    n = 0;
    rd = 1'b0;
    hit = 1'b0;
    forever begin
      if (rd) begin
        for (i = 6; i >= 0; i--) @(negedge scl) #2 sdaLow = ~rdByte[i];
        @(negedge scl) #2 sdaLow = 1'b0;
        @(posedge scl) rd = ~sda;
        if (rd) @(negedge scl) #2 sdaLow = ~rdByte[7];
      end else begin
        for (i = 0; i < 8; i++) @(posedge scl) b = {b[6:0], sda};
        if (n == 0) begin
          hit = b[7:1] == ADDR || b[7:3] == 5'h1E;
          rd = hit & b[0];
          firstByte = b;
        end else if (hit) lastByte = b;
        n++;
        @(negedge scl) #2 sdaLow = hit;
        @(negedge scl) #2 sdaLow = rd & ~rdByte[7];
      end
    end
  endtask : frame

  // a data edge with the clock high is a condition, never a bit
  always @(sda) if (scl === 1'b1) begin
    disable frame;
    sdaLow = 1'b0;
    if (sda === 1'b0) fork
      frame();
    join_none
  end

  // hold the clock low a while after every fall
  always @(negedge scl) if (stretch) begin
    sclLow = 1'b1;
    #300 sclLow = 1'b0;
  end
endmodule : i2cm_slave_model
